/* File: phy_status_pkg.sv */
package phy_status_pkg;
	localparam logic [4:0] REG_GENERAL_STATUS = 5'h18;
	localparam logic [4:0] REG_EXTERNAL_STATUS = 5'h19;
	localparam logic [4:0] REG_LINK_FAIL_COUNTERS = 5'h1a;
	localparam logic [4:0] REG_COMMON_CONFIGURATION = 5'h1b;
	// general status fields
	localparam int GS_PLL_LOCK = 14;
	localparam int GS_LOCAL_WAKE = 13;
	localparam int GS_REMOTE_WAKE = 12;
	localparam int GS_DATA_WAKE = 11;
	localparam int GS_EN_LOW = 10;
	localparam int GS_HW_RESET = 9;
	localparam int GS_FAIL_LO = 3;
	localparam int GS_FAIL_HI = 7;
	// external status fields
	localparam int ES_UV_D33 = 15;
	localparam int ES_UV_A33 = 14;
	localparam int ES_UV_D18 = 13;
	localparam int ES_UV_IO = 11;
	localparam int ES_TEMP_HIGH = 10;
	localparam int ES_TEMP_WARN = 9;
	localparam int ES_SHORT = 8;
	localparam int ES_OPEN = 7;
	localparam int ES_POLARITY = 6;
	localparam int ES_INTERLEAVE = 5;
	// common configuration fields
	localparam int CC_AUTONOMOUS = 15;
	localparam int CC_CLK_LO = 12;
	localparam int CC_CLK_HI = 13;
	localparam int CC_REGULATOR = 11;
	localparam logic [1:0] CLK_MODE_RESET = 2'h0;
	localparam logic [15:0] CC_WRITE_MASK = 16'hb800;
	localparam int FAIL_W = 5;
	localparam int RXCNT_W = 8;
	typedef enum logic [1:0] {
		CLK_XTAL = 2'h0,
		CLK_XTAL_OUT = 2'h1,
		CLK_EXT25 = 2'h2,
		CLK_REF50 = 2'h3
	} clk_mode_t;
endpackage

/* File: phy_status_diag_registers.sv */
`timescale 1ns/1ps
// How it works
// - bit 14 general status: pll lock, latched low
// - bit 13 general status: local wake-up, latched high
// - bit 12 general status: remote wake-up over cable, latched high
// - bit 11: data or tx enable seen in sleep request mode, latched high
// - read clears wake bits; detection stays disarmed until state transition completes
// - bit 10: enable pin went low since last read
// - bit 9: hardware reset since last read
// - bits 7:3 count link fails, cleared on read
// - counters and cable bits keep values when link control is off
// - external bits 15,14,13,11 latch supply undervoltages
// - external bit 10 high temperature, bit 9 temperature warning, latched
// - external bit 8 short, bit 7 open, latched, cleared on read
// - external bit 6 live polarity inversion, not latched
// - external bit 5 interleave order, 0 a-before-b, 1 b-before-a
// - bits 15:8 count local receiver not ok, saturating
// - bits 7:0 count remote receiver not ok, saturating
// - reading link fail counter register clears both receiver counters
// - clock mode bits 13:12 select reference clock source
// - bit 11: 0 internal regulator, 1 external 1.8 v supply
// - autonomous and regulator bits reset from pin straps
module phy_status_diag_registers #(
	parameter int FAIL_WIDTH = phy_status_pkg::FAIL_W,
	parameter int RXCNT_WIDTH = phy_status_pkg::RXCNT_W
) (
	input wire logic clk_sys, // 20 mhz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic reg_rd, // register read strobe, one cycle
	input wire logic reg_wr, // register write strobe, one cycle
	input wire logic [4:0] reg_addr, // register number
	input wire logic [15:0] reg_wdata, // write data
	output logic [15:0] reg_rdata, // read data, registered
	input wire logic pll_locked, // pll stable and locked (async)
	input wire logic local_wake_in, // local wake detect (async)
	input wire logic remote_wake_in, // remote wake detect (async)
	input wire logic sleep_request, // in sleep request mode
	input wire logic rx_data_valid, // receive data valid
	input wire logic mac_tx_en, // mac transmit enable (async)
	input wire logic enable_pin, // enable pin level (async)
	input wire logic state_transition_done, // operating state transition finished, pulse
	input wire logic link_fail_event, // link fail, one-cycle pulse
	input wire logic digital_3v3_undervoltage, // supply monitor (async)
	input wire logic analog_3v3_undervoltage, // supply monitor (async)
	input wire logic digital_1v8_undervoltage, // supply monitor (async)
	input wire logic io_supply_undervoltage, // supply monitor (async)
	input wire logic temp_high_in, // above high temperature (async)
	input wire logic temp_warn_in, // above warning temperature (async)
	input wire logic short_event, // cable short detected, pulse
	input wire logic open_event, // cable open detected, pulse
	input wire logic polarity_inverted, // live polarity inversion
	input wire logic interleave_b_first, // detected symbol order b before a
	input wire logic local_rx_not_ok, // local receiver not ok
	input wire logic remote_rx_not_ok, // remote receiver not ok
	input wire logic strap_autonomous, // strap pin for autonomous mode
	input wire logic strap_regulator, // strap pin for regulator mode
	output logic autonomous_select, // managed/autonomous operation
	output phy_status_pkg::clk_mode_t clk_mode, // reference clock source
	output logic regulator_select // 1 = external 1.8 v supply
);
	import phy_status_pkg::*;

	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 10;
	// reset loads each pin's idle level: only the enable pin idles high,
	// so a low filtered copy after reset would fake an enable-low event
	localparam logic [NSYNC-1:0] PINS_IDLE = 10'h020;
	logic [NSYNC-1:0] pins_raw;
	logic [NSYNC-1:0] sync1, sync2, sync3, pins;
	assign pins_raw = {
		pll_locked,
		local_wake_in,
		remote_wake_in,
		mac_tx_en,
		enable_pin,
		digital_3v3_undervoltage,
		analog_3v3_undervoltage,
		digital_1v8_undervoltage,
		io_supply_undervoltage,
		temp_high_in
	};

	always_ff @(posedge clk_sys) begin
		sync1 <= pins_raw;
		sync2 <= sync1;
		sync3 <= sync2;
	end

	// a change only counts when stages two and three agree
	logic [NSYNC-1:0] agree;
	assign agree = sync2 ~^ sync3;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pins <= PINS_IDLE;
		end else begin
			pins <= (agree & sync3) | (~agree & pins);
		end
	end

	logic warn_s1, warn_s2, warn_s3, warn_q;
	always_ff @(posedge clk_sys) begin
		warn_s1 <= temp_warn_in;
		warn_s2 <= warn_s1;
		warn_s3 <= warn_s2;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			warn_q <= 1'b0;
		end else if (warn_s2 == warn_s3) begin
			warn_q <= warn_s3;
		end
	end

	logic pll_q, lwake_q, rwake_q, txen_q, en_q, uv_d33_q, uv_a33_q, uv_d18_q, uv_io_q, thigh_q;
	assign {
		pll_q,
		lwake_q,
		rwake_q,
		txen_q,
		en_q,
		uv_d33_q,
		uv_a33_q,
		uv_d18_q,
		uv_io_q,
		thigh_q
	} = pins;

	// ----------------------------------------
	// read strobes
	// ----------------------------------------
	logic rd_gs, rd_es, rd_lf;
	assign rd_gs = reg_rd && reg_addr == REG_GENERAL_STATUS;
	assign rd_es = reg_rd && reg_addr == REG_EXTERNAL_STATUS;
	assign rd_lf = reg_rd && reg_addr == REG_LINK_FAIL_COUNTERS;

	// ----------------------------------------
	// general status
	// ----------------------------------------
	logic pll_flag, local_wake_flag, remote_wake_flag, data_wake_flag, en_low_flag, hw_reset_flag;
	logic wake_armed;
	logic [FAIL_WIDTH-1:0] link_fail_count;
	logic data_seen;
	assign data_seen = sleep_request && (rx_data_valid || txen_q);

	// reading disarms wake detection until the state machine settles
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wake_armed <= 1'b1;
		end else if (rd_gs) begin
			wake_armed <= 1'b0;
		end else if (state_transition_done) begin
			wake_armed <= 1'b1;
		end
	end

	// set wins over the read clear in every latched bit
	// data wake may be faked by an io undervoltage; the host masks it then
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			local_wake_flag <= 1'b0;
			remote_wake_flag <= 1'b0;
			data_wake_flag <= 1'b0;
		end else begin
			local_wake_flag <= (wake_armed && lwake_q) || (local_wake_flag && !rd_gs);
			remote_wake_flag <= (wake_armed && rwake_q) || (remote_wake_flag && !rd_gs);
			data_wake_flag <= (wake_armed && data_seen) || (data_wake_flag && !rd_gs);
		end
	end

	// pll starts low: unlocked until a read after lock
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pll_flag <= 1'b0;
		end else begin
			pll_flag <= pll_q && (pll_flag || rd_gs);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_low_flag <= 1'b0;
			hw_reset_flag <= 1'b1;
		end else begin
			en_low_flag <= !en_q || (en_low_flag && !rd_gs);
			hw_reset_flag <= hw_reset_flag && !rd_gs;
		end
	end

	// no wrap: the count holds at its top value
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			link_fail_count <= '0;
		end else if (rd_gs) begin
			link_fail_count <= {{(FAIL_WIDTH-1){1'b0}}, link_fail_event};
		end else if (link_fail_event && !(&link_fail_count)) begin
			link_fail_count <= link_fail_count + 1'b1;
		end
	end

	// ----------------------------------------
	// external status
	// ----------------------------------------
	logic [5:0] ext_now, ext_flags;
	assign ext_now = {
		uv_d33_q,
		uv_a33_q,
		uv_d18_q,
		uv_io_q,
		thigh_q,
		warn_q
	};
	logic short_flag, open_flag;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ext_flags <= '0;
		end else begin
			ext_flags <= ext_now | (ext_flags & {6{!rd_es}});
		end
	end

	// kept through link control off: nothing but reset or read clears them
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			short_flag <= 1'b0;
			open_flag <= 1'b0;
		end else begin
			short_flag <= short_event || (short_flag && !rd_es);
			open_flag <= open_event || (open_flag && !rd_es);
		end
	end

	// ----------------------------------------
	// receiver counters
	// ----------------------------------------
	logic [RXCNT_WIDTH-1:0] local_rx_bad_count, remote_rx_bad_count;
	always_ff @(posedge clk_sys) begin
		if (sys_rst || rd_lf) begin
			local_rx_bad_count <= '0;
		end else if (local_rx_not_ok && !(&local_rx_bad_count)) begin
			local_rx_bad_count <= local_rx_bad_count + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || rd_lf) begin
			remote_rx_bad_count <= '0;
		end else if (remote_rx_not_ok && !(&remote_rx_bad_count)) begin
			remote_rx_bad_count <= remote_rx_bad_count + 1'b1;
		end
	end

	// ----------------------------------------
	// common configuration
	// ----------------------------------------
	logic strap_pending;
	logic [15:0] cfg_kept;

	// straps are pins too; their chain runs through reset and has settled by release
	logic [1:0] strap_s1, strap_s2, strap_s3;
	always_ff @(posedge clk_sys) begin
		strap_s1 <= {strap_autonomous, strap_regulator};
		strap_s2 <= strap_s1;
		strap_s3 <= strap_s2;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			strap_pending <= 1'b1;
		end else begin
			strap_pending <= 1'b0;
		end
	end

	// straps are caught by the first clock after release, not by the reset itself
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			autonomous_select <= 1'b0;
			regulator_select <= 1'b0;
			clk_mode <= clk_mode_t'(CLK_MODE_RESET);
			cfg_kept <= '0;
		end else if (strap_pending) begin
			autonomous_select <= strap_s3[1];
			regulator_select <= strap_s3[0];
		end else if (reg_wr && reg_addr == REG_COMMON_CONFIGURATION) begin
			autonomous_select <= reg_wdata[CC_AUTONOMOUS];
			clk_mode <= clk_mode_t'(reg_wdata[CC_CLK_HI:CC_CLK_LO]);
			regulator_select <= reg_wdata[CC_REGULATOR];
			cfg_kept <= reg_wdata & ~CC_WRITE_MASK;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// the mux is built every cycle, but only a read moves the output
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		case (reg_addr)
			REG_GENERAL_STATUS: begin
				next_rdata[GS_PLL_LOCK] = pll_flag;
				next_rdata[GS_LOCAL_WAKE] = local_wake_flag;
				next_rdata[GS_REMOTE_WAKE] = remote_wake_flag;
				next_rdata[GS_DATA_WAKE] = data_wake_flag;
				next_rdata[GS_EN_LOW] = en_low_flag;
				next_rdata[GS_HW_RESET] = hw_reset_flag;
				next_rdata[GS_FAIL_HI:GS_FAIL_LO] = FAIL_W'(link_fail_count);
			end
			REG_EXTERNAL_STATUS: begin
				next_rdata[ES_UV_D33] = ext_flags[5];
				next_rdata[ES_UV_A33] = ext_flags[4];
				next_rdata[ES_UV_D18] = ext_flags[3];
				next_rdata[ES_UV_IO] = ext_flags[2];
				next_rdata[ES_TEMP_HIGH] = ext_flags[1];
				next_rdata[ES_TEMP_WARN] = ext_flags[0];
				next_rdata[ES_SHORT] = short_flag;
				next_rdata[ES_OPEN] = open_flag;
				next_rdata[ES_POLARITY] = polarity_inverted;
				next_rdata[ES_INTERLEAVE] = interleave_b_first;
			end
			REG_LINK_FAIL_COUNTERS: begin
				next_rdata = {RXCNT_W'(local_rx_bad_count), RXCNT_W'(remote_rx_bad_count)};
			end
			REG_COMMON_CONFIGURATION: begin
				next_rdata = cfg_kept;
				next_rdata[CC_AUTONOMOUS] = autonomous_select;
				next_rdata[CC_CLK_HI:CC_CLK_LO] = clk_mode;
				next_rdata[CC_REGULATOR] = regulator_select;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// held between reads, so the host may sample it late
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end
endmodule

/* File: phy_status_monitor.sv */
`timescale 1ns/1ps
module phy_status_monitor (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // sync reset, high
	input wire logic reg_rd, // read strobe
	input wire logic reg_wr, // write strobe
	input wire logic [4:0] reg_addr, // register number
	input wire logic [15:0] reg_wdata, // write data
	input wire logic [15:0] reg_rdata, // read data
	input wire logic polarity_inverted, // live polarity
	input wire logic interleave_b_first, // live symbol order
	input wire logic regulator_select, // regulator mode
	input wire phy_status_pkg::clk_mode_t clk_mode // clock source
);
	import phy_status_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ------------------------------
	// read path
	// ------------------------------
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[5'h18:5'h1b]}) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_polarity_live: assert property (reg_rd && reg_addr == REG_EXTERNAL_STATUS |=>
		reg_rdata[ES_POLARITY] == $past(polarity_inverted)) else $error("polarity bit not live");
	a_interleave_live: assert property (reg_rd && reg_addr == REG_EXTERNAL_STATUS |=>
		reg_rdata[ES_INTERLEAVE] == $past(interleave_b_first)) else $error("interleave bit wrong");
	a_rx_clear: assert property (reg_rd && reg_addr == REG_LINK_FAIL_COUNTERS ##1
		reg_rd && reg_addr == REG_LINK_FAIL_COUNTERS |=> reg_rdata[15:8] <= 8'h01 && reg_rdata[7:0] <= 8'h01)
		else $error("receiver counters not cleared by read");
	// ------------------------------
	// configuration
	// ------------------------------
	a_clk_write: assert property (reg_wr && reg_addr == REG_COMMON_CONFIGURATION && !$past(sys_rst) |=>
		clk_mode == $past(reg_wdata[13:12])) else $error("clock mode not written");
	a_regulator_write: assert property (reg_wr && reg_addr == REG_COMMON_CONFIGURATION && !$past(sys_rst) |=>
		regulator_select == $past(reg_wdata[CC_REGULATOR])) else $error("regulator mode not written");
	a_cfg_readback: assert property (reg_rd && reg_addr == REG_COMMON_CONFIGURATION |=>
		reg_rdata[13:12] == $past(clk_mode) && reg_rdata[11] == $past(regulator_select))
		else $error("config readback wrong");
	a_write_refused: assert property (reg_wr && reg_addr != REG_COMMON_CONFIGURATION && !$past(sys_rst) |=>
		$stable(clk_mode) && $stable(regulator_select)) else $error("stray write changed config");
	c_rx_pair: cover property (reg_rd && reg_addr == REG_LINK_FAIL_COUNTERS ##1 reg_rd);
	c_cfg_write: cover property (reg_wr && reg_addr == REG_COMMON_CONFIGURATION);
	c_polarity: cover property (reg_rd && reg_addr == REG_EXTERNAL_STATUS ##1 reg_rdata[ES_POLARITY]);
endmodule

/* File: sm_host_model.sv */
`timescale 1ns/1ps
module sm_host_model (
	input wire logic clk_sys, // system clock
	output logic reg_rd, // read strobe
	output logic reg_wr, // write strobe
	output logic [4:0] reg_addr, // register number
	output logic [15:0] reg_wdata // write data
);
	int seed = 14821;
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
	end
	function automatic int rnd();
		return $random(seed);
	endfunction
	// released bus carries junk, so a stale address never passes for a real one
	task automatic idle();
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 5'(rnd());
		reg_wdata = 16'(rnd());
	endtask
	task automatic rd(input logic [4:0] a);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_wr = 1'b0;
		reg_addr = a;
		reg_wdata = 16'(rnd());
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import phy_status_pkg::*;
	logic clk_sys, sys_rst, reg_rd, reg_wr, taken, autonomous_select, regulator_select;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic pll_locked, local_wake_in, remote_wake_in, sleep_request, rx_data_valid, mac_tx_en, enable_pin;
	logic state_transition_done, link_fail_event, short_event, open_event, temp_high_in, temp_warn_in;
	logic digital_3v3_undervoltage, analog_3v3_undervoltage, digital_1v8_undervoltage, io_supply_undervoltage;
	logic polarity_inverted, interleave_b_first, local_rx_not_ok, remote_rx_not_ok, strap_autonomous, strap_regulator;
	clk_mode_t clk_mode;
	int n_mismatch = 0;
	int checks = 0;
	int k;
	logic [15:0] qe[$], qm[$];
	phy_status_diag_registers dut (.*);
	sm_host_model host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic expect_rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		qm.push_back(m);
		qe.push_back(e);
		host.rd(a);
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys) taken <= reg_rd;
	always @(negedge clk_sys) begin
		if (taken === 1'b1 && qe.size() > 0) begin
			check("reg_rdata", reg_rdata & qm.pop_front(), qe.pop_front());
		end
	end
	initial begin
		#(5000 * 50);
		n_mismatch++;
		stop_test();
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{pll_locked, enable_pin, strap_autonomous, sys_rst} = 4'hf;
		{local_wake_in, remote_wake_in, sleep_request, rx_data_valid, mac_tx_en, state_transition_done} = 6'h00;
		{link_fail_event, short_event, open_event, temp_high_in, temp_warn_in} = 5'h00;
		{digital_3v3_undervoltage, analog_3v3_undervoltage, digital_1v8_undervoltage, io_supply_undervoltage} = 4'h0;
		{polarity_inverted, interleave_b_first, local_rx_not_ok, remote_rx_not_ok, strap_regulator} = 5'h00;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (8) host.idle();
		expect_rd(REG_COMMON_CONFIGURATION, 16'hb800, 16'h8000);
		check("strap outputs", {14'h0000, autonomous_select, regulator_select}, 16'h0002);
		expect_rd(REG_GENERAL_STATUS, 16'h7ef8, 16'h0200);
		expect_rd(REG_GENERAL_STATUS, 16'h7ef8, 16'h4000);
		host.idle();
		@(negedge clk_sys) state_transition_done = 1'b1;
		@(negedge clk_sys) state_transition_done = 1'b0;
		k = (host.rnd() & 3) + 1;
		{pll_locked, local_wake_in, remote_wake_in, sleep_request, mac_tx_en, enable_pin} = 6'b011110;
		repeat (k) begin
			@(negedge clk_sys) link_fail_event = 1'b1;
			@(negedge clk_sys) link_fail_event = 1'b0;
		end
		repeat (8) @(negedge clk_sys);
		{pll_locked, local_wake_in, remote_wake_in, sleep_request, mac_tx_en, enable_pin} = 6'b100001;
		repeat (8) @(negedge clk_sys);
		// io supply healthy here, so the data wake flag is trusted
		expect_rd(REG_GENERAL_STATUS, 16'h7ef8, 16'h3c00 | 16'(k << 3));
		expect_rd(REG_GENERAL_STATUS, 16'h7ef8, 16'h4000);
		host.idle();
		local_wake_in = 1'b1;
		repeat (8) @(negedge clk_sys);
		local_wake_in = 1'b0;
		repeat (8) @(negedge clk_sys);
		expect_rd(REG_GENERAL_STATUS, 16'h2000, 16'h0000);
		host.idle();
		// re-armed by a state transition, line data in sleep request sets the data wake flag
		@(negedge clk_sys) state_transition_done = 1'b1;
		@(negedge clk_sys) {state_transition_done, sleep_request, rx_data_valid} = 3'b011;
		@(negedge clk_sys) {sleep_request, rx_data_valid} = 2'b00;
		expect_rd(REG_GENERAL_STATUS, 16'h3800, 16'h0800);
		host.idle();
		{digital_3v3_undervoltage, analog_3v3_undervoltage, digital_1v8_undervoltage, io_supply_undervoltage} = 4'hf;
		{temp_high_in, temp_warn_in, polarity_inverted, interleave_b_first, short_event, open_event} = 6'h3f;
		@(negedge clk_sys) {short_event, open_event} = 2'b00;
		repeat (8) @(negedge clk_sys);
		{digital_3v3_undervoltage, analog_3v3_undervoltage, digital_1v8_undervoltage, io_supply_undervoltage} = 4'h0;
		{temp_high_in, temp_warn_in} = 2'b00;
		repeat (8) @(negedge clk_sys);
		expect_rd(REG_EXTERNAL_STATUS, 16'hefe0, 16'hefe0);
		expect_rd(REG_EXTERNAL_STATUS, 16'hefe0, 16'h0060);
		host.idle();
		{polarity_inverted, interleave_b_first} = 2'b00;
		host.idle();
		expect_rd(REG_EXTERNAL_STATUS, 16'hefe0, 16'h0000);
		host.idle();
		k = (host.rnd() & 63) + 1;
		{local_rx_not_ok, remote_rx_not_ok} = 2'b11;
		repeat (k) @(negedge clk_sys);
		remote_rx_not_ok = 1'b0;
		repeat (300) @(negedge clk_sys);
		local_rx_not_ok = 1'b0;
		expect_rd(REG_LINK_FAIL_COUNTERS, 16'hffff, 16'hff00 | 16'(k));
		expect_rd(REG_LINK_FAIL_COUNTERS, 16'hffff, 16'h0000);
		// every clock mode, each followed by a stray write that must be refused
		for (int i = 0; i < 4; i++) begin
			host.wr(REG_COMMON_CONFIGURATION, {2'b00, 2'(i), i[0], 11'h000});
			host.wr(REG_EXTERNAL_STATUS, 16'hffff);
			expect_rd(REG_COMMON_CONFIGURATION, 16'hb800, {2'b00, 2'(i), i[0], 11'h000});
			check("clk_mode", 16'(clk_mode), 16'(i));
			check("regulator_select", 16'(regulator_select), 16'(i[0]));
		end
		expect_rd(5'h05, 16'hffff, 16'h0000);
		host.idle();
		{strap_autonomous, strap_regulator, sys_rst} = 3'b011;
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (8) host.idle();
		expect_rd(REG_COMMON_CONFIGURATION, 16'hb800, 16'h0800);
		check("strap outputs", {14'h0000, autonomous_select, regulator_select}, 16'h0001);
		repeat (2) host.idle();
		stop_test();
	end
endmodule
bind phy_status_diag_registers phy_status_monitor mon (.*);
